//--- rtl/mcpi_pkg.sv
// What this block does
// - both size registers always readable; writes to them change nothing
// - low size register continuously shows register, eeprom and ram straps
// - low size bit 7 shows register space strap, 0 is 1K, 1 is 2K
// - low size bits 5:4 show eeprom strap, 0K 2K 4K 8K
// - ram strap gives 2K to 16K allocation and its mappable region size
// - ram base after reset follows ram position reset value 0x09
// - smaller ram sits at top or bottom of region per ram position bit 0, set is top
// - high size bits 7:6 show program memory strap, 0K 16K 48K 64K
// - 48K and 64K lower half access gated by high half only bit
// - high size bits 1:0 show the paging split strap
// - page index maps a 16K block into window 0x8000 to 0xBFFF
// - page bits 5:0 are a plain binary page number 0 to 63
// - page index always readable; writable always or only in special modes
// - page reset is 0x00 if always writable, else 0x3C
// - bus write to page index takes effect one cycle later
// - call and return reach page index by a dedicated fast path
// - upper page values are internal window accesses per paging strap
package mcpi_pkg;

   typedef struct packed {
      logic       reg_space;
      logic [1:0] eeprom;
      logic [2:0] ram;
      logic       prog_hi;
      logic       prog_lo;
      logic       pag_hi;
      logic       pag_lo;
   } mcpi_strap_s;

   localparam int          ADDR_W         = 12;
   localparam logic [11:0] OFS_SIZE_LOW   = 12'h000;
   localparam logic [11:0] OFS_SIZE_HIGH  = 12'h004;
   localparam logic [11:0] OFS_PAGE       = 12'h008;
   localparam logic [11:0] OFS_RAM_POS    = 12'h00C;
   localparam logic [11:0] OFS_MISC       = 12'h010;

   localparam logic [7:0]  RAM_POS_RST    = 8'h09;
   localparam logic [7:0]  MISC_RST       = 8'h00;
   localparam logic [5:0]  PAGE_RST_ANY   = 6'h00;
   localparam logic [5:0]  PAGE_RST_SPEC  = 6'h3C;

   localparam int          RAM_POS_LSB    = 3;
   localparam int          RAM_ALIGN_BIT  = 0;
   localparam int          HIGH_HALF_BIT  = 1;
   localparam int          PAGE_SHIFT     = 14;

   localparam logic [5:0]  INT_FROM_00    = 6'h38;
   localparam logic [5:0]  INT_FROM_01    = 6'h30;
   localparam logic [5:0]  INT_FROM_10    = 6'h20;
   localparam logic [5:0]  INT_FROM_11    = 6'h00;

   localparam logic [16:0] RAM_UNIT       = 17'h00800;

endpackage : mcpi_pkg

//--- rtl/mcpi_top.sv
`timescale 1ns/1ps
module mcpi_top
   import mcpi_pkg::*;
#(
   parameter bit WRITE_ANY_MODE = 1'b1
) (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire mcpi_strap_s strap_i,
   input  wire logic        special_mode_i,
   input  wire logic        call_wr_i,
   input  wire logic [5:0]  call_wdata_i,
   output logic [5:0]       call_rdata_o,
   output logic [19:0]      window_addr_o,
   output logic             window_internal_o,
   output logic [15:0]      ram_base_o,
   output logic             lower_fixed_enable_o
);

   localparam logic [5:0] PAGE_RST = WRITE_ANY_MODE ? PAGE_RST_ANY : PAGE_RST_SPEC;

   // strap and mode synchronisers
   mcpi_strap_s strap_meta;
   mcpi_strap_s strap_sync;
   logic        special_meta;
   logic        special_sync;

   // bus data phase state
   logic                wr_pend;
   logic [ADDR_W-1:0]   wr_addr;
   logic                next_wr_pend;
   logic [ADDR_W-1:0]   next_wr_addr;
   logic [31:0]         next_hrdata;

   // registers
   logic [5:0] page_index;
   logic [7:0] ram_pos;
   logic [7:0] misc_ctrl;
   logic [5:0] next_page_index;
   logic [7:0] next_ram_pos;
   logic [7:0] next_misc_ctrl;

   // registered outputs
   logic [19:0] next_window_addr;
   logic        next_window_internal;
   logic [15:0] next_ram_base;
   logic        next_lower_fixed;

   // helpers
   logic              addr_take;
   logic [ADDR_W-1:0] addr_ofs;
   logic              page_writable;
   logic [7:0]        size_low;
   logic [7:0]        size_high;
   logic [16:0]       region;
   logic [16:0]       alloc;
   logic [16:0]       region_base;
   logic [16:0]       ram_base_wide;
   logic [5:0]        int_from;

   function automatic logic [5:0] internal_floor(input logic [1:0] split);
      logic [5:0] f;
      f = INT_FROM_11;
      unique case (split)
         2'b00: f = INT_FROM_00;
         2'b01: f = INT_FROM_01;
         2'b10: f = INT_FROM_10;
         2'b11: f = INT_FROM_11;
      endcase
      return f;
   endfunction : internal_floor

   function automatic logic [16:0] region_size(input logic [2:0] sel);
      logic [16:0] r;
      r = RAM_UNIT << 3;
      unique case (sel)
         3'h0:    r = RAM_UNIT;
         3'h1:    r = RAM_UNIT << 1;
         3'h2:    r = RAM_UNIT << 2;
         3'h3:    r = RAM_UNIT << 2;
         default: r = RAM_UNIT << 3;
      endcase
      return r;
   endfunction : region_size

   always_comb begin
      addr_take     = hsel_i && htrans_i[1] && hready_i;
      addr_ofs      = haddr_i[ADDR_W-1:0];
      page_writable = WRITE_ANY_MODE || special_sync;
      size_low  = {strap_sync.reg_space, 1'b0, strap_sync.eeprom, 1'b0, strap_sync.ram};
      size_high = {strap_sync.prog_hi, strap_sync.prog_lo, 4'h0,
                   strap_sync.pag_hi, strap_sync.pag_lo};
   end

   always_comb begin
      next_wr_pend    = 1'b0;
      next_wr_addr    = wr_addr;
      next_hrdata     = 32'h0000_0000;
      next_page_index = page_index;
      next_ram_pos    = ram_pos;
      next_misc_ctrl  = misc_ctrl;
      if (addr_take) begin
         next_wr_pend = hwrite_i;
         next_wr_addr = addr_ofs;
         if (!hwrite_i) begin
            unique case (addr_ofs)
               OFS_SIZE_LOW:  next_hrdata = {24'h0, size_low};
               OFS_SIZE_HIGH: next_hrdata = {24'h0, size_high};
               OFS_PAGE:      next_hrdata = {26'h0, page_index};
               OFS_RAM_POS:   next_hrdata = {24'h0, ram_pos};
               OFS_MISC:      next_hrdata = {24'h0, misc_ctrl};
               default:       next_hrdata = 32'h0000_0000;
            endcase
         end
      end
      // size registers have no write path
      if (wr_pend) begin
         unique case (wr_addr)
            OFS_PAGE: begin
               if (page_writable) begin
                  next_page_index = hwdata_i[5:0];
               end
            end
            OFS_RAM_POS: next_ram_pos = hwdata_i[7:0];
            OFS_MISC:    next_misc_ctrl = {6'h00, hwdata_i[HIGH_HALF_BIT], 1'b0};
            default:     next_misc_ctrl = misc_ctrl;
         endcase
      end
      if (call_wr_i) begin
         next_page_index = call_wdata_i;
      end
   end

   always_comb begin
      next_window_addr = {next_page_index, {PAGE_SHIFT{1'b0}}};
      int_from = internal_floor({strap_sync.pag_hi, strap_sync.pag_lo});
      next_window_internal = (next_page_index >= int_from);
      region        = region_size(strap_sync.ram);
      alloc         = RAM_UNIT * ({14'h0, strap_sync.ram} + 17'h1);
      region_base   = {1'b0, next_ram_pos[7:RAM_POS_LSB], 11'h000} & ~(region - 17'h1);
      ram_base_wide = next_ram_pos[RAM_ALIGN_BIT] ? region_base + region - alloc : region_base;
      next_ram_base = ram_base_wide[15:0];
      next_lower_fixed = !(strap_sync.prog_hi && next_misc_ctrl[HIGH_HALF_BIT]);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         strap_meta   <= '0;
         strap_sync   <= '0;
         special_meta <= 1'b0;
         special_sync <= 1'b0;
      end else begin
         strap_meta   <= strap_i;
         strap_sync   <= strap_meta;
         special_meta <= special_mode_i;
         special_sync <= special_meta;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_pend              <= 1'b0;
         wr_addr              <= '0;
         hrdata_o             <= 32'h0000_0000;
         hreadyout_o          <= 1'b1;
         hresp_o              <= 1'b0;
         page_index           <= PAGE_RST;
         ram_pos              <= RAM_POS_RST;
         misc_ctrl            <= MISC_RST;
         window_addr_o        <= {PAGE_RST, {PAGE_SHIFT{1'b0}}};
         window_internal_o    <= (PAGE_RST >= INT_FROM_00);
         ram_base_o           <= 16'h0000;
         lower_fixed_enable_o <= 1'b0;
      end else begin
         wr_pend              <= next_wr_pend;
         wr_addr              <= next_wr_addr;
         hrdata_o             <= next_hrdata;
         hreadyout_o          <= 1'b1;
         hresp_o              <= 1'b0;
         page_index           <= next_page_index;
         ram_pos              <= next_ram_pos;
         misc_ctrl            <= next_misc_ctrl;
         window_addr_o        <= next_window_addr;
         window_internal_o    <= next_window_internal;
         ram_base_o           <= next_ram_base;
         lower_fixed_enable_o <= next_lower_fixed;
      end
   end

   assign call_rdata_o = page_index;

   // checks
   sequence s_read_of(logic [11:0] ofs);
      hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[11:0] == ofs;
   endsequence

   sequence s_page_bus_write;
      wr_pend && wr_addr == OFS_PAGE && !call_wr_i;
   endsequence

   property p_size_low_reflect;
      @(posedge clk_i) disable iff (reset_i)
      s_read_of(OFS_SIZE_LOW) |=> hrdata_o == {24'h0, $past(size_low)};
   endproperty
   a_size_low_reflect: assert property (p_size_low_reflect)
      else $error("low size register read wrong");

   property p_size_low_layout;
      @(posedge clk_i) disable iff (reset_i)
      s_read_of(OFS_SIZE_LOW) |=> hrdata_o[7] == $past(strap_sync.reg_space)
         && hrdata_o[5:4] == $past(strap_sync.eeprom) && hrdata_o[6] == 1'b0 && hrdata_o[3] == 1'b0;
   endproperty
   a_size_low_layout: assert property (p_size_low_layout)
      else $error("low size field layout wrong");

   property p_size_high_reflect;
      @(posedge clk_i) disable iff (reset_i)
      s_read_of(OFS_SIZE_HIGH) |=> hrdata_o[7:6] == $past({strap_sync.prog_hi, strap_sync.prog_lo})
         && hrdata_o[5:2] == 4'h0 && hrdata_o[1:0] == $past({strap_sync.pag_hi, strap_sync.pag_lo});
   endproperty
   a_size_high_reflect: assert property (p_size_high_reflect)
      else $error("high size register read wrong");

   property p_page_bus_write;
      @(posedge clk_i) disable iff (reset_i)
      s_page_bus_write and page_writable |=> page_index == $past(hwdata_i[5:0])
         && window_addr_o[19:14] == $past(hwdata_i[5:0]);
   endproperty
   a_page_bus_write: assert property (p_page_bus_write)
      else $error("page bus write not applied one cycle later");

   property p_page_locked;
      @(posedge clk_i) disable iff (reset_i)
      s_page_bus_write and !page_writable |=> $stable(page_index);
   endproperty
   a_page_locked: assert property (p_page_locked)
      else $error("page changed while not writable");

   property p_call_write;
      @(posedge clk_i) disable iff (reset_i)
      call_wr_i |=> call_rdata_o == $past(call_wdata_i);
   endproperty
   a_call_write: assert property (p_call_write)
      else $error("call path write not complete");

   property p_window_addr;
      @(posedge clk_i) disable iff (reset_i)
      1'b1 |=> window_addr_o == {page_index, 14'h0000};
   endproperty
   a_window_addr: assert property (p_window_addr)
      else $error("window address does not follow page");

   property p_window_internal;
      @(posedge clk_i) disable iff (reset_i)
      1'b1 |=> window_internal_o == (page_index >= internal_floor($past({strap_sync.pag_hi, strap_sync.pag_lo})));
   endproperty
   a_window_internal: assert property (p_window_internal)
      else $error("internal window decision wrong");

   property p_page_read_zero;
      @(posedge clk_i) disable iff (reset_i)
      s_read_of(OFS_PAGE) |=> hrdata_o[31:6] == 26'h0 && hrdata_o[5:0] == $past(page_index);
   endproperty
   a_page_read_zero: assert property (p_page_read_zero)
      else $error("page read upper bits not zero");

   property p_reset_page;
      @(posedge clk_i)
      reset_i |=> page_index == PAGE_RST && ram_pos == RAM_POS_RST;
   endproperty
   a_reset_page: assert property (p_reset_page)
      else $error("reset values wrong");

   property p_ram_low_align;
      @(posedge clk_i) disable iff (reset_i)
      !ram_pos[RAM_ALIGN_BIT] ##1 !ram_pos[RAM_ALIGN_BIT]
         |-> ({1'b0, ram_base_o} & (region_size(strap_sync.ram) - 17'h1)) == 17'h0;
   endproperty
   a_ram_low_align: assert property (p_ram_low_align)
      else $error("bottom aligned ram base not on region");

   property p_lower_fixed;
      @(posedge clk_i) disable iff (reset_i)
      strap_sync.prog_hi && misc_ctrl[HIGH_HALF_BIT] ##1 strap_sync.prog_hi && misc_ctrl[HIGH_HALF_BIT]
         |-> !lower_fixed_enable_o;
   endproperty
   a_lower_fixed: assert property (p_lower_fixed)
      else $error("lower half not gated");

   property p_bus_okay;
      @(posedge clk_i) disable iff (reset_i)
      hsel_i |=> hreadyout_o && !hresp_o;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus answer not ready okay");

endmodule : mcpi_top

//--- testbench/mcpi_core_model.sv
`timescale 1ns/1ps
module mcpi_core_model (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       go_i,
   input  wire logic [1:0] lag_i,
   input  wire logic [5:0] page_i,
   output logic            call_wr_o,
   output logic [5:0]      call_wdata_o,
   output logic            busy_o
);
   logic [1:0] cnt;
   logic [5:0] pg;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt          <= 2'h0;
         pg           <= 6'h00;
         busy_o       <= 1'b0;
         call_wr_o    <= 1'b0;
         call_wdata_o <= 6'h00;
      end else begin
         call_wr_o    <= 1'b0;
         call_wdata_o <= ~pg;
         if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt    <= lag_i;
            pg     <= page_i;
         end else if (busy_o && cnt == 2'h0) begin
            // one-cycle dedicated page write
            busy_o       <= 1'b0;
            call_wr_o    <= 1'b1;
            call_wdata_o <= pg;
         end else if (busy_o) begin
            cnt <= cnt - 2'h1;
         end
      end
   end
endmodule : mcpi_core_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import mcpi_pkg::*;
   logic        clk_i, reset_i, hsel, hwrite, hrdy, hresp, special, call_wr, win_int, lower_fixed, go, busy;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans, lag;
   logic [5:0]  call_wdata, call_rdata, mpage, cur_page, call_rdata2, spec_page;
   logic        hrdy2;
   logic [19:0] win_addr, win_old;
   logic [15:0] ram_base;
   mcpi_strap_s strap;
   int          miscompares, samples_checked, cycles;
   logic [15:0] ram_rst_base [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000, 16'h1800, 16'h1000, 16'h0800, 16'h0000};
   logic [5:0]  thr [4] = '{6'h38, 6'h30, 6'h20, 6'h00};

   mcpi_top i_mcpi_top (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
      .hreadyout_o(hrdy), .hresp_o(hresp), .strap_i(strap), .special_mode_i(special), .call_wr_i(call_wr),
      .call_wdata_i(call_wdata), .call_rdata_o(call_rdata), .window_addr_o(win_addr),
      .window_internal_o(win_int), .ram_base_o(ram_base), .lower_fixed_enable_o(lower_fixed));
   mcpi_core_model i_mcpi_core_model (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .lag_i(lag), .page_i(mpage),
      .call_wr_o(call_wr), .call_wdata_o(call_wdata), .busy_o(busy));
   mcpi_top #(.WRITE_ANY_MODE(1'b0)) i_mcpi_top_spec (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy2),
      .hrdata_o(), .hreadyout_o(hrdy2), .hresp_o(), .strap_i(strap), .special_mode_i(special),
      .call_wr_i(call_wr), .call_wdata_i(call_wdata), .call_rdata_o(call_rdata2), .window_addr_o(),
      .window_internal_o(), .ram_base_o(), .lower_fixed_enable_o());

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_rdy();
      @(negedge clk_i);
      while (hrdy !== 1'b1) begin
         @(negedge clk_i);
      end
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      @(posedge clk_i);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      r       = hrdata;
      chk("resp", 32'h0, {31'h0, hresp});
      win_old = win_addr;
      @(posedge clk_i);
   endtask : bus

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, r);
   endtask : rdchk

   task automatic set_strap(input mcpi_strap_s s);
      strap <= s;
      repeat (4) @(posedge clk_i);
   endtask : set_strap

   task automatic t_reset();
      rdchk("page", OFS_PAGE, {26'h0, PAGE_RST_ANY});
      rdchk("ram pos", OFS_RAM_POS, {24'h0, RAM_POS_RST});
      chk("spec page rst", {26'h0, PAGE_RST_SPEC}, {26'h0, call_rdata2});
      @(negedge clk_i);
      chk("window", 32'h0, {12'h0, win_addr});
      @(posedge clk_i);
      $display("test reset done");
   endtask : t_reset

   task automatic t_low();
      mcpi_strap_s s;
      logic [31:0] e;
      for (int i = 0; i < 8; i++) begin
         s = '{i[2], i[1:0], i[2:0], 1'b0, 1'b0, 1'b0, 1'b0};
         e = {24'h0, i[2], 1'b0, i[1:0], 1'b0, i[2:0]};
         set_strap(s);
         rdchk("size low", OFS_SIZE_LOW, e);
         bus(1'b1, OFS_SIZE_LOW, 32'hFFFFFFFF);
         rdchk("size low kept", OFS_SIZE_LOW, e);
         @(negedge clk_i);
         chk("ram base", {16'h0, ram_rst_base[i]}, {16'h0, ram_base});
         @(posedge clk_i);
      end
      $display("test size low done");
   endtask : t_low

   task automatic t_ram();
      set_strap('{1'b0, 2'h0, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0});
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, OFS_RAM_POS, {24'h0, 7'h04, i[0]});
         repeat (2) @(posedge clk_i);
         @(negedge clk_i);
         chk("ram align", i[0] ? 32'h0800 : 32'h0, {16'h0, ram_base});
         @(posedge clk_i);
      end
      $display("test ram align done");
   endtask : t_ram

   task automatic t_high();
      bus(1'b1, OFS_MISC, 32'h2);
      for (int i = 0; i < 16; i++) begin
         set_strap('{1'b0, 2'h0, 3'h0, i[3], i[2], i[1], i[0]});
         bus(1'b1, OFS_SIZE_HIGH, 32'hFFFFFFFF);
         rdchk("size high", OFS_SIZE_HIGH, {24'h0, i[3:2], 4'h0, i[1:0]});
         @(negedge clk_i);
         chk("lower fixed", {31'h0, ~i[3]}, {31'h0, lower_fixed});
         @(posedge clk_i);
      end
      bus(1'b1, OFS_MISC, 32'h0);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("lower fixed off", 32'h1, {31'h0, lower_fixed});
      @(posedge clk_i);
      $display("test size high done");
   endtask : t_high

   task automatic t_page();
      logic [5:0] v;
      for (int j = 0; j < 8; j++) begin
         special <= j[0];
         set_strap('{1'b0, 2'h0, 3'h0, 1'b0, 1'b0, j[2], j[1]});
         v = thr[j[2:1]] - {5'h0, ~j[0]};
         bus(1'b1, OFS_PAGE, {26'h0, v});
         chk("window old", {12'h0, cur_page, 14'h0}, {12'h0, win_old});
         @(negedge clk_i);
         chk("window new", {12'h0, v, 14'h0}, {12'h0, win_addr});
         chk("internal", {31'h0, v >= thr[j[2:1]]}, {31'h0, win_int});
         if (j[0]) begin
            spec_page = v;
         end
         chk("spec page", {26'h0, spec_page}, {26'h0, call_rdata2});
         @(posedge clk_i);
         cur_page = v;
         rdchk("page rd", OFS_PAGE, {26'h0, v});
      end
      bus(1'b1, OFS_PAGE, 32'hFFFFFFFF);
      cur_page = 6'h3F;
      rdchk("page top", OFS_PAGE, 32'h3F);
      bus(1'b1, 12'h020, 32'hFFFFFFFF);
      rdchk("unmapped", 12'h020, 32'h0);
      $display("test page done");
   endtask : t_page

   task automatic t_call();
      for (int i = 0; i < 3; i++) begin
         go    <= 1'b1;
         lag   <= i[1:0];
         mpage <= 6'h15 + i[5:0];
         @(posedge clk_i);
         go <= 1'b0;
         @(negedge clk_i);
         while (call_wr !== 1'b1) begin
            @(negedge clk_i);
         end
         @(negedge clk_i);
         chk("call page", {26'h0, 6'h15 + i[5:0]}, {26'h0, call_rdata});
         chk("call window", {12'h0, 6'h15 + i[5:0], 14'h0}, {12'h0, win_addr});
         chk("spec call", {26'h0, 6'h15 + i[5:0]}, {26'h0, call_rdata2});
         @(posedge clk_i);
      end
      $display("test call done");
   endtask : t_call

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      reset_i  = 1'b1;
      hsel     = 1'b0;
      haddr    = 32'h0;
      htrans   = 2'h0;
      hwrite   = 1'b0;
      hwdata   = 32'h0;
      strap    = '0;
      special  = 1'b0;
      go       = 1'b0;
      lag      = 2'h0;
      mpage    = 6'h00;
      cur_page = 6'h00;
      spec_page = PAGE_RST_SPEC;
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      t_reset();
      t_low();
      t_ram();
      t_high();
      t_page();
      t_call();
      wrap_up();
   end
endmodule : tb
